// ==== hdl/e1ra_alarm_top.sv ====
// What this block does
// - Submultiframe 1 CRC error bit follows each submultiframe 1 check result.
// - Submultiframe 2 CRC error bit follows each submultiframe 2 check result.
// - Remote failure set after five seconds of E-bit errors over 989, no RAI, aligned.
// - Loss of signal after 255 consecutive zero bits.
// - Loss of signal ends after 255-bit window from a pulse with 12.5% ones.
// - Channel 16 all-ones bit follows channel 16 pattern, evaluated each frame.
// - All-ones alarm bit set on valid AIS, criterion picked by a control bit.
// - Remote alarm bit follows the A bit on each non-alignment frame.
// - Combined bit set for RAI with continuous CRC errors, updated per multiframe.
// - Eighth identical Sa6 nibble raises a flag and latches Sa5 and nibble.
// - Sa6 change flag rises when a nibble differs from the previous one.
// - Reading the Sa6 report clears its latched bits and both flags.
//
// Strobed register access was chosen for this implementation.
module e1ra_alarm_top #(
   // Arbitrary value, not a real device code
   parameter logic [7:0] DEVICE_CODE = 8'h5c
) (
   input  wire logic                         sys_clk_i,
   input  wire logic                         rst_i,
   input  wire logic [e1ra_pkg::ADDR_W-1:0]  reg_addr_i,
   input  wire logic [e1ra_pkg::DATA_W-1:0]  reg_wdata_i,
   input  wire logic                         reg_wr_i,
   input  wire logic                         reg_rd_i,
   output logic      [e1ra_pkg::DATA_W-1:0]  reg_rdata_o,
   output logic                              irq_o,
   input  wire logic                         rx_bit_en_i,
   input  wire logic                         rx_bit_i,
   input  wire logic                         submf_done_i,
   input  wire logic                         submf_second_i,
   input  wire logic                         submf_crc_fail_i,
   input  wire logic                         ebit_err_i,
   input  wire logic                         second_tick_i,
   input  wire logic                         frame_sync_lost_i,
   input  wire logic                         nfas_frame_i,
   input  wire logic                         a_bit_i,
   input  wire logic                         frame_end_i,
   input  wire logic                         ch16_all_ones_i,
   input  wire logic                         multiframe_end_i,
   input  wire logic                         crc_continuous_err_i,
   input  wire logic                         sa6_nibble_valid_i,
   input  wire logic [3:0]                   sa6_nibble_i,
   input  wire logic                         sa5_bit_i
);
   import e1ra_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic              submf1_crc_err_reg;
   logic              submf2_crc_err_reg;
   logic              remote_mf_gen_fail_reg;
   logic              ch16_all_ones_status_reg;
   logic              all_ones_alarm_status_reg;
   logic              remote_alarm_status_reg;
   logic              rai_and_crc_err_status_reg;
   logic [9:0]        ebit_cnt_reg;
   logic              sec_rai_seen_reg;
   logic              sec_sync_lost_reg;
   logic [2:0]        good_secs_reg;
   logic [8:0]        ais_pos_reg;
   logic [1:0]        ais_zeros_reg;
   logic              ais_prev_ok_reg;
   logic [3:0]        sa6_prev_reg;
   logic              sa6_prev_valid_reg;
   logic [3:0]        sa6_repeat_reg;
   logic              sa5_latched_reg;
   logic [3:0]        nibble_latched_reg;
   logic              eight_same_nibble_flag_reg;
   logic              nibble_change_flag_reg;
   logic [DATA_W-1:0] ctrl_reg;
   logic [DATA_W-1:0] irq_status_reg;
   logic [DATA_W-1:0] irq_enable_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic              los_prev_reg;
   logic              ais_prev_reg;
   logic              rai_prev_reg;
   logic              remote_mf_gen_fail_prev_reg;
   logic              ch16_prev_reg;

   // ------------------------------------------------------------
   // Loss of signal detector
   // ------------------------------------------------------------
   e1ra_bit_if los_link ();

   assign los_link.bit_en  = rx_bit_en_i;
   assign los_link.bit_val = rx_bit_i;

   e1ra_los_det u_los_det (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .line      (los_link.det)
   );

   wire logic loss_of_signal = los_link.los;

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   wire logic wr_ctrl    = reg_wr_i && (reg_addr_i == ALARM_CONTROL_OFFS);
   wire logic wr_irq_clr = reg_wr_i && (reg_addr_i == IRQ_CLEAR_OFFS);
   wire logic wr_irq_en  = reg_wr_i && (reg_addr_i == IRQ_ENABLE_OFFS);
   wire logic rd_sa6     = reg_rd_i && (reg_addr_i == SA6_CHANGE_REPORT_OFFS);
   wire logic ais_criterion_select = ctrl_reg[CTRL_AIS_SELECT_BIT];

   wire logic [DATA_W-1:0] alarm_status_one = {
      submf1_crc_err_reg, submf2_crc_err_reg, remote_mf_gen_fail_reg, loss_of_signal,
      ch16_all_ones_status_reg, all_ones_alarm_status_reg, remote_alarm_status_reg,
      rai_and_crc_err_status_reg};

   wire logic [DATA_W-1:0] sa6_change_report = {
      sa5_latched_reg, nibble_latched_reg, 1'b0,
      eight_same_nibble_flag_reg, nibble_change_flag_reg};

   // Unmapped and write-only addresses read as zero
   wire logic [DATA_W-1:0] read_mux =
      (reg_addr_i == ALARM_STATUS_ONE_OFFS)      ? alarm_status_one  :
      (reg_addr_i == SA6_CHANGE_REPORT_OFFS)     ? sa6_change_report :
      (reg_addr_i == DEVICE_IDENTIFICATION_OFFS) ? DEVICE_CODE       :
      (reg_addr_i == ALARM_CONTROL_OFFS)         ? ctrl_reg          :
      (reg_addr_i == IRQ_STATUS_OFFS)            ? irq_status_reg    :
      (reg_addr_i == IRQ_ENABLE_OFFS)            ? irq_enable_reg    : 8'h00;

   // ------------------------------------------------------------
   // Remote failure evaluation
   // ------------------------------------------------------------
   wire logic [9:0] ebit_cnt_next = (ebit_err_i && ebit_cnt_reg != 10'h3ff) ?
                                    ebit_cnt_reg + 10'h001 : ebit_cnt_reg;
   wire logic       rai_now       = nfas_frame_i ? a_bit_i : remote_alarm_status_reg;
   wire logic       sec_good      = (ebit_cnt_next > EBIT_ERR_LIMIT) &&
                                    !(sec_rai_seen_reg || rai_now) &&
                                    !(sec_sync_lost_reg || frame_sync_lost_i);
   wire logic [2:0] good_secs_next = !sec_good ? 3'h0 :
                                     (good_secs_reg == REMOTE_MF_GEN_FAIL_SECONDS) ? good_secs_reg :
                                     good_secs_reg + 3'h1;

   // ------------------------------------------------------------
   // AIS window
   // ------------------------------------------------------------
   wire logic [1:0] ais_zeros_next = (rx_bit_i || ais_zeros_reg == 2'h3) ?
                                     ais_zeros_reg : ais_zeros_reg + 2'h1;
   wire logic       ais_window_end = (ais_pos_reg == AIS_WINDOW_LAST);
   wire logic       ais_window_ok  = (ais_zeros_next <= AIS_MAX_ZEROS);

   // ------------------------------------------------------------
   // Sa6 nibble tracking
   // ------------------------------------------------------------
   wire logic       sa6_same      = sa6_prev_valid_reg && (sa6_nibble_i == sa6_prev_reg);
   wire logic       sa6_change    = sa6_nibble_valid_i && sa6_prev_valid_reg && !sa6_same;
   wire logic [3:0] sa6_repeat_next = !sa6_same ? 4'h1 :
                                      (sa6_repeat_reg == SA6_REPEAT) ? sa6_repeat_reg :
                                      sa6_repeat_reg + 4'h1;
   wire logic       sa6_eighth    = sa6_nibble_valid_i && sa6_same &&
                                    (sa6_repeat_reg == SA6_REPEAT - 4'h1);

   // ------------------------------------------------------------
   // Interrupt events
   // ------------------------------------------------------------
   wire logic [DATA_W-1:0] irq_events = {
      ch16_all_ones_status_reg && !ch16_prev_reg,
      submf_done_i && submf_crc_fail_i,
      sa6_change,
      sa6_eighth,
      remote_mf_gen_fail_reg && !remote_mf_gen_fail_prev_reg,
      remote_alarm_status_reg && !rai_prev_reg,
      all_ones_alarm_status_reg && !ais_prev_reg,
      loss_of_signal && !los_prev_reg};

   // ------------------------------------------------------------
   // Alarm status
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         submf1_crc_err_reg         <= STATUS_RESET[STS_SUBMF1_CRC_ERR_BIT];
         submf2_crc_err_reg         <= STATUS_RESET[STS_SUBMF2_CRC_ERR_BIT];
         ch16_all_ones_status_reg   <= STATUS_RESET[STS_CH16_ALL_ONES_BIT];
         remote_alarm_status_reg    <= STATUS_RESET[STS_REMOTE_ALARM_BIT];
         rai_and_crc_err_status_reg <= STATUS_RESET[STS_RAI_AND_CRC_ERR_BIT];
      end else begin
         if (submf_done_i && !submf_second_i) submf1_crc_err_reg <= submf_crc_fail_i;
         if (submf_done_i && submf_second_i) submf2_crc_err_reg <= submf_crc_fail_i;
         if (frame_end_i) ch16_all_ones_status_reg <= ch16_all_ones_i;
         if (nfas_frame_i) remote_alarm_status_reg <= a_bit_i;
         if (multiframe_end_i) begin
            rai_and_crc_err_status_reg <= remote_alarm_status_reg && crc_continuous_err_i;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ebit_cnt_reg           <= 10'h000;
         sec_rai_seen_reg       <= 1'b0;
         sec_sync_lost_reg      <= 1'b0;
         good_secs_reg          <= 3'h0;
         remote_mf_gen_fail_reg <= STATUS_RESET[STS_REMOTE_MF_FAIL_BIT];
      end else if (second_tick_i) begin
         ebit_cnt_reg           <= 10'h000;
         sec_rai_seen_reg       <= 1'b0;
         sec_sync_lost_reg      <= 1'b0;
         good_secs_reg          <= good_secs_next;
         remote_mf_gen_fail_reg <= (good_secs_next == REMOTE_MF_GEN_FAIL_SECONDS);
      end else begin
         ebit_cnt_reg      <= ebit_cnt_next;
         sec_rai_seen_reg  <= sec_rai_seen_reg || rai_now;
         sec_sync_lost_reg <= sec_sync_lost_reg || frame_sync_lost_i;
      end
   end

   // Two-window mode trades detection latency for fewer false alarms
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ais_pos_reg               <= 9'h000;
         ais_zeros_reg             <= 2'h0;
         ais_prev_ok_reg           <= 1'b0;
         all_ones_alarm_status_reg <= STATUS_RESET[STS_ALL_ONES_ALARM_BIT];
      end else if (rx_bit_en_i) begin
         ais_pos_reg <= ais_pos_reg + 9'h001;
         if (ais_window_end) begin
            ais_zeros_reg   <= 2'h0;
            ais_prev_ok_reg <= ais_window_ok;
            all_ones_alarm_status_reg <= ais_criterion_select ?
                                         (ais_window_ok && ais_prev_ok_reg) : ais_window_ok;
         end else begin
            ais_zeros_reg <= ais_zeros_next;
         end
      end
   end

   // ------------------------------------------------------------
   // Sa6 report
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sa6_prev_reg               <= 4'h0;
         sa6_prev_valid_reg         <= 1'b0;
         sa6_repeat_reg             <= 4'h0;
         sa5_latched_reg            <= 1'b0;
         nibble_latched_reg         <= 4'h0;
         eight_same_nibble_flag_reg <= 1'b0;
         nibble_change_flag_reg     <= 1'b0;
      end else begin
         if (sa6_nibble_valid_i) begin
            sa6_prev_reg       <= sa6_nibble_i;
            sa6_prev_valid_reg <= 1'b1;
            sa6_repeat_reg     <= sa6_repeat_next;
         end
         // A new event in the read cycle survives the clear
         if (sa6_eighth) begin
            sa5_latched_reg            <= sa5_bit_i;
            nibble_latched_reg         <= sa6_nibble_i;
            eight_same_nibble_flag_reg <= 1'b1;
         end else if (rd_sa6) begin
            sa5_latched_reg            <= 1'b0;
            nibble_latched_reg         <= 4'h0;
            eight_same_nibble_flag_reg <= 1'b0;
         end
         nibble_change_flag_reg <= sa6_change || (nibble_change_flag_reg && !rd_sa6);
      end
   end

   // ------------------------------------------------------------
   // Control, interrupts and read port
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl_reg       <= CTRL_RESET;
         irq_enable_reg <= IRQ_ENABLE_RESET;
         irq_status_reg <= 8'h00;
         rdata_reg      <= 8'h00;
         los_prev_reg   <= 1'b0;
         ais_prev_reg   <= 1'b0;
         rai_prev_reg   <= 1'b0;
         remote_mf_gen_fail_prev_reg <= 1'b0;
         ch16_prev_reg  <= 1'b0;
      end else begin
         // Only control and interrupt registers are writable
         if (wr_ctrl) ctrl_reg <= reg_wdata_i;
         if (wr_irq_en) irq_enable_reg <= reg_wdata_i;
         irq_status_reg <= irq_events | (irq_status_reg & ~(wr_irq_clr ? reg_wdata_i : 8'h00));
         rdata_reg      <= reg_rd_i ? read_mux : 8'h00;
         los_prev_reg   <= loss_of_signal;
         ais_prev_reg   <= all_ones_alarm_status_reg;
         rai_prev_reg   <= remote_alarm_status_reg;
         remote_mf_gen_fail_prev_reg <= remote_mf_gen_fail_reg;
         ch16_prev_reg  <= ch16_all_ones_status_reg;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign irq_o       = |(irq_status_reg & irq_enable_reg);

endmodule

// ==== hdl/e1ra_los_det.sv ====
module e1ra_los_det (
   input  wire logic  sys_clk_i,
   input  wire logic  rst_i,
   e1ra_bit_if.det    line
);
   import e1ra_pkg::*;

   e1ra_los_state_t state_reg;
   logic [7:0]      zero_run_reg;
   logic [7:0]      pos_reg;
   logic [7:0]      ones_reg;

   wire logic [7:0] zero_run_next = line.bit_val ? 8'h00 : e1ra_sat_inc8(zero_run_reg);
   wire logic [7:0] ones_next     = line.bit_val ? e1ra_sat_inc8(ones_reg) : ones_reg;
   wire logic       zero_run_hit  = (zero_run_next == LOS_ZERO_RUN);
   wire logic       window_last   = (pos_reg == LOS_WINDOW_LEN - 8'h01);
   wire logic       density_ok    = (ones_next >= LOS_MIN_ONES);

   // ------------------------------------------------------------
   // Detector
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_reg    <= LOS_IDLE;
         zero_run_reg <= 8'h00;
         pos_reg      <= 8'h00;
         ones_reg     <= 8'h00;
      end else if (line.bit_en) begin
         case (state_reg)
            LOS_IDLE: begin
               zero_run_reg <= zero_run_next;
               if (zero_run_hit) state_reg <= LOS_ACTIVE;
            end
            LOS_ACTIVE: begin
               // Window only opens on a pulse
               if (line.bit_val) begin
                  state_reg <= LOS_WINDOW;
                  pos_reg   <= 8'h01;
                  ones_reg  <= 8'h01;
               end
            end
            LOS_WINDOW: begin
               pos_reg  <= pos_reg + 8'h01;
               ones_reg <= ones_next;
               if (window_last) begin
                  // Failed window waits for the next pulse
                  state_reg    <= density_ok ? LOS_IDLE : LOS_ACTIVE;
                  zero_run_reg <= 8'h00;
               end
            end
            default: state_reg <= LOS_IDLE;
         endcase
      end
   end

   assign line.los = (state_reg != LOS_IDLE);

endmodule

// ==== include/e1ra_bit_if.sv ====
interface e1ra_bit_if;
   logic bit_en;
   logic bit_val;
   logic los;

   modport src (output bit_en, output bit_val, input los);
   modport det (input bit_en, input bit_val, output los);
endinterface

// ==== include/e1ra_pkg.sv ====
package e1ra_pkg;

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;

   localparam logic [ADDR_W-1:0] ALARM_STATUS_ONE_OFFS      = 5'h19;
   localparam logic [ADDR_W-1:0] SA6_CHANGE_REPORT_OFFS     = 5'h1a;
   localparam logic [ADDR_W-1:0] DEVICE_IDENTIFICATION_OFFS = 5'h1f;
   localparam logic [ADDR_W-1:0] ALARM_CONTROL_OFFS         = 5'h10;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFS            = 5'h11;
   localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFFS             = 5'h12;
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFFS            = 5'h13;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int STS_SUBMF1_CRC_ERR_BIT   = 7;
   localparam int STS_SUBMF2_CRC_ERR_BIT   = 6;
   localparam int STS_REMOTE_MF_FAIL_BIT   = 5;
   localparam int STS_LOSS_OF_SIGNAL_BIT   = 4;
   localparam int STS_CH16_ALL_ONES_BIT    = 3;
   localparam int STS_ALL_ONES_ALARM_BIT   = 2;
   localparam int STS_REMOTE_ALARM_BIT     = 1;
   localparam int STS_RAI_AND_CRC_ERR_BIT  = 0;

   localparam int SA6_REPORT_SA5_BIT       = 7;
   localparam int SA6_REPORT_NIBBLE_LSB    = 3;
   localparam int SA6_REPORT_EIGHT_BIT     = 1;
   localparam int SA6_REPORT_CHANGE_BIT    = 0;

   localparam int CTRL_AIS_SELECT_BIT      = 0;

   localparam int IRQ_LOS_BIT              = 0;
   localparam int IRQ_AIS_BIT              = 1;
   localparam int IRQ_RAI_BIT              = 2;
   localparam int IRQ_REMOTE_MF_GEN_FAIL_BIT            = 3;
   localparam int IRQ_EIGHT_SAME_BIT       = 4;
   localparam int IRQ_NIBBLE_CHANGE_BIT    = 5;
   localparam int IRQ_CRC_ERR_BIT          = 6;
   localparam int IRQ_CH16_AIS_BIT         = 7;

   // ------------------------------------------------------------
   // Reset values and counts
   // ------------------------------------------------------------
   localparam logic [DATA_W-1:0] STATUS_RESET     = 8'h00;
   localparam logic [DATA_W-1:0] CTRL_RESET       = 8'h00;
   localparam logic [DATA_W-1:0] IRQ_ENABLE_RESET = 8'h00;

   localparam logic [7:0] LOS_ZERO_RUN    = 8'hff;
   localparam logic [7:0] LOS_WINDOW_LEN  = 8'hff;
   localparam logic [7:0] LOS_MIN_ONES    = 8'h20;
   localparam logic [9:0] EBIT_ERR_LIMIT  = 10'h3dd;
   localparam logic [2:0] REMOTE_MF_GEN_FAIL_SECONDS   = 3'h5;
   localparam logic [8:0] AIS_WINDOW_LAST = 9'h1ff;
   localparam logic [1:0] AIS_MAX_ZEROS   = 2'h2;
   localparam logic [3:0] SA6_REPEAT      = 4'h8;

   typedef enum logic [1:0] {
      LOS_IDLE   = 2'b00,
      LOS_ACTIVE = 2'b01,
      LOS_WINDOW = 2'b10
   } e1ra_los_state_t;

   function automatic logic [7:0] e1ra_sat_inc8(input logic [7:0] v);
      e1ra_sat_inc8 = (v == 8'hff) ? v : v + 8'h01;
   endfunction

endpackage

// ==== sim/e1ra_alarm_sva.sv ====
module e1ra_alarm_sva #(
   parameter logic [7:0] DEVICE_CODE = 8'h5c
) (
   input  wire logic                        sys_clk_i,
   input  wire logic                        rst_i,
   input  wire logic [e1ra_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [e1ra_pkg::DATA_W-1:0] reg_wdata_i,
   input  wire logic                        reg_wr_i,
   input  wire logic                        reg_rd_i,
   input  wire logic [e1ra_pkg::DATA_W-1:0] reg_rdata_o,
   input  wire logic                        irq_o,
   input  wire logic                        submf_done_i,
   input  wire logic                        submf_second_i,
   input  wire logic                        submf_crc_fail_i,
   input  wire logic                        nfas_frame_i,
   input  wire logic                        a_bit_i,
   input  wire logic                        frame_end_i,
   input  wire logic                        ch16_all_ones_i,
   input  wire logic                        sa6_nibble_valid_i
);
   import e1ra_pkg::*;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data without read");
   a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 5'h05 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_id_code: assert property (reg_rd_i && reg_addr_i == 5'h1f |=> reg_rdata_o == DEVICE_CODE)
      else $error("identification word wrong");
   a_crc1_follow: assert property (submf_done_i && !submf_second_i ##1 reg_rd_i && reg_addr_i == 5'h19
      |=> reg_rdata_o[7] == $past(submf_crc_fail_i, 2)) else $error("submf1 crc bit wrong");
   a_crc2_follow: assert property (submf_done_i && submf_second_i ##1 reg_rd_i && reg_addr_i == 5'h19
      |=> reg_rdata_o[6] == $past(submf_crc_fail_i, 2)) else $error("submf2 crc bit wrong");
   a_remote_alarm: assert property (nfas_frame_i ##1 reg_rd_i && reg_addr_i == 5'h19
      |=> reg_rdata_o[1] == $past(a_bit_i, 2)) else $error("remote alarm bit wrong");
   a_ch16_follow: assert property (frame_end_i ##1 reg_rd_i && reg_addr_i == 5'h19
      |=> reg_rdata_o[3] == $past(ch16_all_ones_i, 2)) else $error("ch16 bit wrong");
   a_sa6_read_clear: assert property (reg_rd_i && reg_addr_i == 5'h1a && !sa6_nibble_valid_i
      ##1 !sa6_nibble_valid_i ##1 reg_rd_i && reg_addr_i == 5'h1a |=> reg_rdata_o == 8'h00)
      else $error("sa6 report not cleared");
   a_irq_masked: assert property (reg_wr_i && reg_addr_i == 5'h13 && reg_wdata_i == 8'h00 |=> !irq_o)
      else $error("irq high with no enable");
endmodule

// ==== sim/e1ra_alarm_top_bench.sv ====
module e1ra_alarm_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import e1ra_pkg::*;
   // Arbitrary value, not a real device code
   localparam logic [7:0] DEV_CODE = 8'h3c;
   logic sys_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, submf_done_i = 0, submf_second_i = 0;
   logic submf_crc_fail_i = 0, ebit_err_i = 0, second_tick_i = 0, nfas_frame_i = 0, a_bit_i = 0;
   logic frame_end_i = 0, ch16_all_ones_i = 0, multiframe_end_i = 0, crc_continuous_err_i = 0, frame_sync_lost_i = 0;
   logic sa6_nibble_valid_i = 0, sa5_bit_i = 0, rx_bit_en_i, rx_bit_i, irq_o;
   logic [4:0] reg_addr_i = '0;
   logic [7:0] reg_wdata_i = '0, reg_rdata_o;
   logic [3:0] sa6_nibble_i = '0;
   logic [1:0] line_mode = 2'h2;
   int err_count = 0, total_checks = 0;
   always #2 sys_clk_i = ~sys_clk_i;
   e1ra_line_model u_line (.clk_i(sys_clk_i), .rst_i, .mode_i(line_mode), .bit_en_o(rx_bit_en_i), .bit_o(rx_bit_i));
   e1ra_alarm_top #(.DEVICE_CODE(DEV_CODE)) uut (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .irq_o, .rx_bit_en_i, .rx_bit_i, .submf_done_i, .submf_second_i,
      .submf_crc_fail_i, .ebit_err_i, .second_tick_i, .frame_sync_lost_i, .nfas_frame_i, .a_bit_i,
      .frame_end_i, .ch16_all_ones_i, .multiframe_end_i, .crc_continuous_err_i, .sa6_nibble_valid_i,
      .sa6_nibble_i, .sa5_bit_i);
   // ------------------------------------------------------------
   // Bus cycles and comparison
   // ------------------------------------------------------------
   task cyc(input int n); repeat (n) @(posedge sys_clk_i); endtask
   task conclude();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task wr(input logic [4:0] a, input logic [7:0] d);
      reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1; cyc(1); reg_wr_i <= 0; cyc(1);
   endtask
   // Read data only stand in the cycle after the strobe
   task rc(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
      reg_addr_i <= a; reg_rd_i <= 1; cyc(1); reg_rd_i <= 0; #1 chk(reg_rdata_o & m, e); cyc(1);
   endtask
   task nfas(input logic v); nfas_frame_i <= 1; a_bit_i <= v; cyc(1); nfas_frame_i <= 0; endtask
   task nib(input logic [3:0] n); sa6_nibble_valid_i <= 1; sa6_nibble_i <= n; sa5_bit_i <= 1; cyc(1);
      sa6_nibble_valid_i <= 0; cyc(1); endtask
   task sec(input int n); ebit_err_i <= 1; cyc(n); ebit_err_i <= 0; second_tick_i <= 1; cyc(1);
      second_tick_i <= 0; endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_regs();
      wr(5'h1f, 8'h00); rc(5'h1f, 8'hff, DEV_CODE);
      wr(5'h19, 8'hff); rc(5'h19, 8'hff, 8'h00);
      rc(5'h05, 8'hff, 8'h00); rc(5'h12, 8'hff, 8'h00);
      $display("registers done");
   endtask
   task t_crc();
      // Second pass clears the bits that the first pass set
      for (int i = 0; i < 8; i++) begin
         submf_done_i <= 1; submf_second_i <= i[0]; submf_crc_fail_i <= i[1]; cyc(1); submf_done_i <= 0;
         rc(5'h19, i[0] ? 8'h40 : 8'h80, i[1] ? (i[0] ? 8'h40 : 8'h80) : 8'h00);
      end
      $display("crc done");
   endtask
   task t_combined();
      nfas(1); crc_continuous_err_i <= 1; multiframe_end_i <= 1; cyc(1); multiframe_end_i <= 0;
      rc(5'h19, 8'h01, 8'h01);
      crc_continuous_err_i <= 0; multiframe_end_i <= 1; cyc(1); multiframe_end_i <= 0;
      rc(5'h19, 8'h01, 8'h00);
      $display("combined done");
   endtask
   task t_alarms();
      for (int v = 1; v >= 0; v--) begin
         nfas(v[0]); rc(5'h19, 8'h02, {6'h0, v[0], 1'b0});
         frame_end_i <= 1; ch16_all_ones_i <= v[0]; cyc(1); frame_end_i <= 0;
         rc(5'h19, 8'h08, {4'h0, v[0], 3'h0});
      end
      wr(5'h12, 8'hff); wr(5'h13, 8'h04); chk({7'h0, irq_o}, 8'h00);
      nfas(1); cyc(3); chk({7'h0, irq_o}, 8'h01); rc(5'h11, 8'h04, 8'h04);
      wr(5'h13, 8'h00); chk({7'h0, irq_o}, 8'h00);
      wr(5'h12, 8'h04); wr(5'h13, 8'h04); chk({7'h0, irq_o}, 8'h00); nfas(0);
      $display("alarms done");
   endtask
   task t_sa6();
      repeat (7) nib(4'h5);
      rc(5'h1a, 8'hff, 8'h00); nib(4'h5); rc(5'h1a, 8'hff, 8'haa);
      rc(5'h1a, 8'hff, 8'h00);
      nib(4'h3); rc(5'h1a, 8'hff, 8'h01);
      wr(5'h1a, 8'hff); rc(5'h1a, 8'hff, 8'h00);
      $display("sa6 done");
   endtask
   task t_line();
      line_mode <= 2'h0; cyc(300); rc(5'h19, 8'h10, 8'h10);
      line_mode <= 2'h2; cyc(600); rc(5'h19, 8'h10, 8'h00);
      line_mode <= 2'h1; cyc(1100); rc(5'h19, 8'h04, 8'h04);
      line_mode <= 2'h2; cyc(1100); rc(5'h19, 8'h04, 8'h00);
      wr(5'h10, 8'h01); line_mode <= 2'h1; cyc(1600); rc(5'h19, 8'h04, 8'h04);
      line_mode <= 2'h2; cyc(1100); rc(5'h19, 8'h04, 8'h00);
      $display("line done");
   endtask
   task t_remote_mf_gen_fail();
      sec(1);
      repeat (4) sec(990);
      rc(5'h19, 8'h20, 8'h00); sec(990); rc(5'h19, 8'h20, 8'h20);
      sec(989); rc(5'h19, 8'h20, 8'h00);
      // Sync loss, then a remote alarm, spoils an otherwise good fifth second
      for (int k = 0; k < 2; k++) begin
         repeat (4) sec(990);
         frame_sync_lost_i <= !k[0]; nfas(k[0]); frame_sync_lost_i <= 1'b0; cyc(1);
         nfas(1'b0); sec(990); rc(5'h19, 8'h20, 8'h00);
      end
      $display("remote_mf_gen_fail done");
   endtask
   initial begin
      cyc(60000);
      err_count++;
      conclude();
   end
   initial begin
      cyc(4); rst_i <= 0;
      t_regs(); t_crc(); t_combined(); t_alarms(); t_sa6(); t_line(); t_remote_mf_gen_fail();
      conclude();
   end
endmodule
bind e1ra_alarm_top e1ra_alarm_sva #(.DEVICE_CODE(DEVICE_CODE)) u_sva (.sys_clk_i, .rst_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o, .submf_done_i, .submf_second_i, .submf_crc_fail_i,
   .nfas_frame_i, .a_bit_i, .frame_end_i, .ch16_all_ones_i, .sa6_nibble_valid_i);

// ==== sim/e1ra_line_model.sv ====
// ------------------------------------------------------------
// Far-end line: 0 all zeros, 1 all ones, 2 one pulse in eight
// ------------------------------------------------------------
module e1ra_line_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [1:0] mode_i,
   output logic            bit_en_o,
   output logic            bit_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] phase_reg;
   // One bit per clock keeps the LOS and AIS windows short in time
   always_ff @(posedge clk_i) begin
      phase_reg <= rst_i ? 3'h0 : phase_reg + 3'h1;
      bit_en_o  <= !rst_i;
      bit_o     <= (mode_i == 2'h1) || (mode_i == 2'h2 && phase_reg == 3'h0);
   end
endmodule
